// file: hdl/pset_pkg.sv
// shared constants, types and helpers for the parameter set store manager
package pset_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int PSET_WORDS = 8;
	localparam int USER_SLOTS = 3;

	typedef enum logic [2:0] {
		SLOT_FACT_DEFAULT = 3'h0,
		SLOT_HIGH_GAIN = 3'h1,
		SLOT_AUTO_FUNC = 3'h2,
		SLOT_USER1 = 3'h3,
		SLOT_USER2 = 3'h4,
		SLOT_USER3 = 3'h5
	} slot_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_STORE = 3'b010,
		ST_RESTORE = 3'b100
	} copy_state_t;

	typedef struct packed {
		logic rejected;
		logic boot_done;
		logic acq_idle;
		logic busy;
	} status_t;

	localparam logic [ADDR_W-1:0] OFS_CHOOSER = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STARTUP = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ACT_IDX = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ACT_DATA = 8'h14;

	localparam int CMD_STORE_BIT = 0;
	localparam int CMD_RESTORE_BIT = 1;
	localparam int STATUS_REJ_BIT = 3;

	localparam slot_t CHOOSER_RESET = SLOT_FACT_DEFAULT;
	localparam slot_t STARTUP_RESET = SLOT_FACT_DEFAULT;

	// arbitrary marker so factory words are recognisable on a bench
	localparam logic [15:0] FACTORY_TAG = 16'hFAC0;

	function automatic logic slot_valid(input logic [2:0] v);
		return v <= SLOT_USER3;
	endfunction : slot_valid

	function automatic logic is_user(input slot_t s);
		return s >= SLOT_USER1;
	endfunction : is_user

	function automatic logic [1:0] user_index(input slot_t s);
		logic [2:0] d;
		d = s - SLOT_USER1;
		return d[1:0];
	endfunction : user_index

	function automatic logic [DATA_W-1:0] factory_word(input slot_t s,
		input logic [7:0] idx);
		return {FACTORY_TAG, 5'h00, s, idx};
	endfunction : factory_word

endpackage : pset_pkg

// file: hdl/nv_slot_store.sv
// non-volatile user slots and the startup slot choice
`timescale 1ns/1ns
module nv_slot_store #(
	parameter int WORDS = pset_pkg::PSET_WORDS,
	parameter int IDX_W = $clog2(pset_pkg::PSET_WORDS)
) (
	input wire logic i_clk,
	input wire logic i_nv_init,
	input wire logic i_wr_en,
	input wire logic [1:0] i_wr_slot,
	input wire logic [IDX_W-1:0] i_wr_idx,
	input wire logic [pset_pkg::DATA_W-1:0] i_wr_data,
	input wire logic [1:0] i_rd_slot,
	input wire logic [IDX_W-1:0] i_rd_idx,
	output logic [pset_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_startup_wr,
	input wire pset_pkg::slot_t i_startup_val,
	output pset_pkg::slot_t o_startup
);

	// warm reset does not reach here: only the power-on init clears it
	logic [pset_pkg::DATA_W-1:0] mem [pset_pkg::USER_SLOTS*WORDS];
	pset_pkg::slot_t next_startup;

	function automatic int addr_of(input logic [1:0] s,
		input logic [IDX_W-1:0] i);
		return int'(s) * WORDS + int'(i);
	endfunction : addr_of

	always_comb begin
		next_startup = o_startup;
		if (i_startup_wr) begin
			next_startup = i_startup_val;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_nv_init) begin
			o_startup <= pset_pkg::STARTUP_RESET;
		end else begin
			o_startup <= next_startup;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_nv_init) begin
			for (int k = 0; k < pset_pkg::USER_SLOTS * WORDS; k++) begin
				mem[k] <= '0;
			end
		end else if (i_wr_en) begin
			mem[addr_of(i_wr_slot, i_wr_idx)] <= i_wr_data; // R5
		end
	end

	assign o_rd_data = mem[addr_of(i_rd_slot, i_rd_idx)];

	user_range_a: assert property (@(posedge i_clk) disable iff (i_nv_init)
		i_wr_en |-> i_wr_slot < 2'(pset_pkg::USER_SLOTS)) // R14
		else $error("write aimed outside the user slots");

endmodule : nv_slot_store

// file: hdl/parameter_set_store_manager.sv
// parameter set store manager: apb registers, copy engine, startup restore
// How it works
// R1: software sets the slot chooser to one of six slots before acting.
// R2: slot chooser points at the factory default slot after reset.
// R3: store may only target user slots 1 to 3.
// R4: store copies the active set into the chosen user slot.
// R5: store overwrites every word previously held in that slot.
// R6: store is taken only while acquisition is idle.
// R7: restore copies the chosen factory or user slot into the active set.
// R8: restored words drive the active set outputs at once.
// R9: restore is taken only while acquisition is idle.
// R10: any of the six slots may be the startup slot.
// R11: after every reset the startup slot is copied into the active set.
// R12: startup slot changes are taken only while acquisition is idle.
// R13: startup slot has its own chooser apart from the slot chooser.
// R14: factory slots are constants and can never be written.
// R15: active set is volatile and cleared by reset before the restore.
// R16: restore leaves the luminance lookup table untouched.
// R17: sequencer set values are never part of any slot.
// R18: refused requests change nothing and raise a sticky rejected flag; a bad slot chooser code is ignored without setting it.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module parameter_set_store_manager #(
	parameter int WORDS = pset_pkg::PSET_WORDS
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_nv_init,
	input wire logic i_acq_continuous,
	input wire logic i_acq_single_pending,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [pset_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [pset_pkg::DATA_W-1:0] i_pwdata,
	output logic [pset_pkg::DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [WORDS-1:0][pset_pkg::DATA_W-1:0] o_active_set,
	output logic o_busy
);

	localparam int IDX_W = $clog2(WORDS);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(WORDS - 1);

	pset_pkg::copy_state_t state_q, next_state;
	logic [IDX_W-1:0] idx_q, next_idx;
	pset_pkg::slot_t src_q, next_src;
	pset_pkg::slot_t chooser_q, next_chooser;
	logic [IDX_W-1:0] act_idx_q, next_act_idx;
	logic [WORDS-1:0][pset_pkg::DATA_W-1:0] next_active;
	logic rejected_q, next_rejected;
	logic boot_done_q, next_boot_done;
	logic [pset_pkg::DATA_W-1:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_busy;

	logic acq_idle, idle_ok, setup, access, wr;
	logic reject_evt, mem_wr, startup_wr;
	pset_pkg::slot_t startup, rsrc, wslot;
	logic [pset_pkg::DATA_W-1:0] mem_rd, src_word;
	pset_pkg::status_t status;

	function automatic logic addr_hit(input logic [pset_pkg::ADDR_W-1:0] a);
		return a == pset_pkg::OFS_CHOOSER || a == pset_pkg::OFS_STARTUP ||
			a == pset_pkg::OFS_CMD || a == pset_pkg::OFS_STATUS ||
			a == pset_pkg::OFS_ACT_IDX || a == pset_pkg::OFS_ACT_DATA;
	endfunction : addr_hit

	assign acq_idle = !i_acq_continuous && !i_acq_single_pending;
	// a copy in flight counts as not idle, so commands never overlap
	assign idle_ok = acq_idle && state_q == pset_pkg::ST_IDLE;
	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable && o_pready;
	assign wr = access && i_pwrite;
	assign wslot = pset_pkg::slot_t'(i_pwdata[2:0]);

	// the boot restore reads the startup chooser, later ones the latched slot
	assign rsrc = boot_done_q ? src_q : startup; // R11
	assign src_word = pset_pkg::is_user(rsrc) ? mem_rd : // R7
		pset_pkg::factory_word(rsrc, 8'(idx_q)); // R14

	assign status = '{rejected: rejected_q, boot_done: boot_done_q,
		acq_idle: acq_idle, busy: state_q != pset_pkg::ST_IDLE};

	nv_slot_store #(
		.WORDS(WORDS),
		.IDX_W(IDX_W)
	) u_nv (
		.i_clk(i_clk),
		.i_nv_init(i_nv_init),
		.i_wr_en(mem_wr),
		.i_wr_slot(pset_pkg::user_index(src_q)),
		.i_wr_idx(idx_q),
		.i_wr_data(o_active_set[idx_q]),
		.i_rd_slot(pset_pkg::user_index(rsrc)),
		.i_rd_idx(idx_q),
		.o_rd_data(mem_rd),
		.i_startup_wr(startup_wr),
		.i_startup_val(wslot),
		.o_startup(startup)
	);

	always_comb begin
		next_state = state_q;
		next_idx = idx_q;
		next_src = src_q;
		next_chooser = chooser_q;
		next_act_idx = act_idx_q;
		next_active = o_active_set;
		next_rejected = rejected_q;
		next_boot_done = boot_done_q;
		reject_evt = 1'b0;
		mem_wr = 1'b0;
		startup_wr = 1'b0;

		if (wr) begin
			case (i_paddr)
				pset_pkg::OFS_CHOOSER: begin
					if (pset_pkg::slot_valid(i_pwdata[2:0])) begin
						next_chooser = wslot; // R1
					end
				end
				pset_pkg::OFS_STARTUP: begin
					if (!pset_pkg::slot_valid(i_pwdata[2:0])) begin
						reject_evt = 1'b1; // R18
					end else if (idle_ok) begin
						startup_wr = 1'b1; // R10 R12 R13
					end else begin
						reject_evt = 1'b1; // R12
					end
				end
				pset_pkg::OFS_CMD: begin
					if (i_pwdata[pset_pkg::CMD_STORE_BIT]) begin
						if (idle_ok && pset_pkg::is_user(chooser_q)) begin
							next_state = pset_pkg::ST_STORE; // R3 R6
							next_src = chooser_q;
							next_idx = '0;
						end else begin
							reject_evt = 1'b1; // R18
						end
					end else if (i_pwdata[pset_pkg::CMD_RESTORE_BIT]) begin
						if (idle_ok) begin
							next_state = pset_pkg::ST_RESTORE; // R9
							next_src = chooser_q;
							next_idx = '0;
						end else begin
							reject_evt = 1'b1; // R18
						end
					end
				end
				pset_pkg::OFS_STATUS: begin
					if (i_pwdata[pset_pkg::STATUS_REJ_BIT]) begin
						next_rejected = 1'b0;
					end
				end
				pset_pkg::OFS_ACT_IDX: begin
					next_act_idx = i_pwdata[IDX_W-1:0];
				end
				pset_pkg::OFS_ACT_DATA: begin
					if (state_q == pset_pkg::ST_IDLE) begin
						next_active[act_idx_q] = i_pwdata;
					end
				end
				default: begin
				end
			endcase
		end

		case (state_q)
			pset_pkg::ST_IDLE: begin
			end
			pset_pkg::ST_STORE: begin
				mem_wr = 1'b1; // R4 R5
				next_idx = idx_q + 1'b1;
				if (idx_q == LAST_IDX) begin
					next_state = pset_pkg::ST_IDLE;
					next_idx = '0;
				end
			end
			pset_pkg::ST_RESTORE: begin
				// only the parameter words live here; lut and sequencer do not
				next_active[idx_q] = src_word; // R8 R16 R17
				next_idx = idx_q + 1'b1;
				if (idx_q == LAST_IDX) begin
					next_state = pset_pkg::ST_IDLE;
					next_idx = '0;
					next_boot_done = 1'b1;
					next_src = rsrc;
				end
			end
			default: begin
				next_state = pset_pkg::ST_IDLE;
			end
		endcase

		// set wins over a clear in the same cycle
		if (reject_evt) begin
			next_rejected = 1'b1; // R18
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q <= pset_pkg::ST_RESTORE; // R11
			idx_q <= '0;
			src_q <= pset_pkg::STARTUP_RESET;
			chooser_q <= pset_pkg::CHOOSER_RESET; // R2
			act_idx_q <= '0;
			o_active_set <= '0; // R15
			rejected_q <= 1'b0;
			boot_done_q <= 1'b0;
		end else begin
			state_q <= next_state;
			idx_q <= next_idx;
			src_q <= next_src;
			chooser_q <= next_chooser;
			act_idx_q <= next_act_idx;
			o_active_set <= next_active;
			rejected_q <= next_rejected;
			boot_done_q <= next_boot_done;
		end
	end

	// read data is captured in the setup cycle, so pready can be a flop
	always_comb begin
		next_prdata = '0;
		next_pready = setup;
		next_pslverr = 1'b0;
		next_busy = next_state != pset_pkg::ST_IDLE;
		if (setup) begin
			case (i_paddr)
				pset_pkg::OFS_CHOOSER: next_prdata = 32'(chooser_q);
				pset_pkg::OFS_STARTUP: next_prdata = 32'(startup);
				pset_pkg::OFS_STATUS: next_prdata = 32'(status);
				pset_pkg::OFS_ACT_IDX: next_prdata = 32'(act_idx_q);
				pset_pkg::OFS_ACT_DATA: next_prdata = o_active_set[act_idx_q];
				default: next_prdata = '0;
			endcase
			next_pslverr = !addr_hit(i_paddr) || (i_pwrite &&
				i_paddr == pset_pkg::OFS_ACT_DATA &&
				state_q != pset_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_prdata <= next_prdata;
			o_pready <= next_pready;
			o_pslverr <= next_pslverr;
			o_busy <= next_busy;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	store_only_idle_a: assert property ( // R6
		$rose(state_q == pset_pkg::ST_STORE) |-> $past(acq_idle))
		else $error("store started while acquisition active");

	restore_only_idle_a: assert property ( // R9
		$rose(state_q == pset_pkg::ST_RESTORE) |->
			$past(acq_idle) && boot_done_q)
		else $error("restore started while acquisition active");

	startup_idle_a: assert property ( // R12
		$changed(startup) && !$past(i_nv_init) |-> $past(idle_ok))
		else $error("startup choice changed while not idle");

	store_user_a: assert property ( // R3
		state_q == pset_pkg::ST_STORE |-> pset_pkg::is_user(src_q))
		else $error("store aimed at a factory slot");

	chooser_reset_a: assert property ( // R2
		$fell(i_reset) |-> chooser_q == pset_pkg::SLOT_FACT_DEFAULT)
		else $error("slot chooser not at factory default after reset");

	boot_restore_a: assert property ( // R11
		$fell(i_reset) |-> state_q == pset_pkg::ST_RESTORE &&
			idx_q == '0 && !boot_done_q)
		else $error("startup restore did not begin after reset");

	store_len_a: assert property ( // R5
		$fell(state_q == pset_pkg::ST_STORE) |-> $past(idx_q) == LAST_IDX)
		else $error("store ended before every word was written");

	restore_word_a: assert property ( // R8
		state_q == pset_pkg::ST_RESTORE |=>
			o_active_set[$past(idx_q)] == $past(src_word))
		else $error("restored word did not reach the active set");

	reject_flag_a: assert property ( // R18
		wr && i_paddr == pset_pkg::OFS_CMD &&
		i_pwdata[pset_pkg::CMD_STORE_BIT] && !acq_idle |=>
			rejected_q && state_q == $past(state_q))
		else $error("refused store was not flagged or changed state");

endmodule : parameter_set_store_manager

// file: tb/tb_parameter_set_store_manager.sv
// self-checking bench for the parameter set store manager
`timescale 1ns/1ns
module tb_parameter_set_store_manager;
	localparam int WORDS = 8;
	logic i_clk, i_reset, i_nv_init, i_acq_continuous, i_acq_single_pending;
	logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_busy, perr;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rdata;
	logic [WORDS-1:0][31:0] o_active_set;
	logic [31:0] exp_set [WORDS];
	logic [31:0] user [3][WORDS];
	int failures = 0;
	int num_checks = 0;

	parameter_set_store_manager #(.WORDS(WORDS)) dut_u (
		.i_clk(i_clk), .i_reset(i_reset), .i_nv_init(i_nv_init),
		.i_acq_continuous(i_acq_continuous),
		.i_acq_single_pending(i_acq_single_pending),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_active_set(o_active_set), .o_busy(o_busy)
	);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask : chk

	// one apb transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1);
		chk(32'(n), 32'h1, "pready wait states");
		rdata = o_prdata;
		perr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string msg);
		apb(1'b0, a, 32'h0);
		chk(rdata, e, msg);
	endtask : rd

	task automatic wait_idle();
		int n;
		repeat (2) @(posedge i_clk);
		n = 0;
		while (o_busy !== 1'b0 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		chk({31'h0, o_busy}, 32'h0, "copy stuck");
		if (n >= 50) wrap_up();
	endtask : wait_idle

	task automatic cmd(input logic [2:0] s, input logic [31:0] c);
		wr(pset_pkg::OFS_CHOOSER, {29'h0, s});
		wr(pset_pkg::OFS_CMD, c);
		wait_idle();
	endtask : cmd

	// expected words of a slot: factory constant or the bench's copy
	task automatic load_exp(input int s);
		for (int k = 0; k < WORDS; k++) begin
			if (s < 3) begin
				exp_set[k] = {pset_pkg::FACTORY_TAG, 5'h0, 3'(s), 8'(k)};
			end else begin
				exp_set[k] = user[s-3][k];
			end
		end
	endtask : load_exp

	task automatic fill(input logic [31:0] base);
		for (int k = 0; k < WORDS; k++) begin
			wr(pset_pkg::OFS_ACT_IDX, 32'(k));
			wr(pset_pkg::OFS_ACT_DATA, base + 32'(k));
			exp_set[k] = base + 32'(k);
		end
	endtask : fill

	task automatic chk_active(input string msg);
		@(negedge i_clk);
		for (int k = 0; k < WORDS; k++) begin
			chk(o_active_set[k], exp_set[k], msg);
		end
	endtask : chk_active

	task automatic do_reset();
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk(o_active_set[0], 32'h0, "active kept in reset");
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		i_nv_init <= 1'b0;
		wait_idle();
	endtask : do_reset

	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		$display("CHECK FAILED at %0t: timeout", $time);
		wrap_up();
	end

	initial begin
		logic [2:0] s;
		i_reset = 1'b1;
		i_nv_init = 1'b1;
		i_acq_continuous = 1'b0;
		i_acq_single_pending = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		for (int u = 0; u < 3; u++) begin
			for (int k = 0; k < WORDS; k++) user[u][k] = 32'h0;
		end
		do_reset();
		load_exp(0);
		chk_active("boot restore");
		rd(pset_pkg::OFS_CHOOSER, 32'h0, "chooser reset");
		rd(pset_pkg::OFS_STATUS, 32'h6, "status idle");
		// user2 stored twice so the second pattern must replace the first
		for (int u = 0; u < 4; u++) begin
			s = (u < 3) ? 3'(u + 3) : 3'h4;
			fill(32'hA000_0000 + 32'h0100_0000 * u);
			chk_active("active write");
			cmd(s, 32'h1);
			for (int k = 0; k < WORDS; k++) user[s-3][k] = exp_set[k];
		end
		cmd(3'h0, 32'h1);
		rd(pset_pkg::OFS_STATUS, 32'hE, "factory store");
		chk_active("active after refusal");
		wr(pset_pkg::OFS_STATUS, 32'h8);
		for (int m = 0; m < 2; m++) begin
			i_acq_continuous <= (m == 0);
			i_acq_single_pending <= (m == 1);
			cmd(3'h3, 32'h2);
			cmd(3'h3, 32'h1);
			wr(pset_pkg::OFS_STARTUP, 32'h4);
			rd(pset_pkg::OFS_STATUS, 32'hC, "acq refusal");
			chk_active("active during acq");
			rd(pset_pkg::OFS_STARTUP, 32'h0, "startup during acq");
			wr(pset_pkg::OFS_STATUS, 32'h8);
		end
		i_acq_continuous <= 1'b0;
		i_acq_single_pending <= 1'b0;
		for (int t = 0; t < 6; t++) begin
			cmd(3'(t), 32'h2);
			load_exp(t);
			chk_active("restore");
		end
		wr(pset_pkg::OFS_CHOOSER, 32'h6);
		rd(pset_pkg::OFS_CHOOSER, 32'h5, "bad chooser code");
		for (int t = 5; t >= 0; t--) begin
			wr(pset_pkg::OFS_STARTUP, 32'(t));
			rd(pset_pkg::OFS_STARTUP, 32'(t), "startup choice");
		end
		wr(pset_pkg::OFS_STARTUP, 32'h4);
		wr(pset_pkg::OFS_CHOOSER, 32'h1);
		do_reset();
		load_exp(4);
		chk_active("startup restore");
		rd(pset_pkg::OFS_CHOOSER, 32'h0, "chooser after reset");
		rd(pset_pkg::OFS_STARTUP, 32'h4, "own chooser");
		apb(1'b0, 8'h40, 32'h0);
		chk(rdata, 32'h0, "unmapped data");
		chk({31'h0, perr}, 32'h1, "unmapped error");
		wrap_up();
	end

endmodule : tb_parameter_set_store_manager
